// File: design/dmx_exec.sv
// execution of the four data-move instructions over a four-phase cycle
`timescale 1ns/1ps
module dmx_exec (
  // clock and reset
  input wire logic sys_clk,
  input wire logic nrst,
  // instruction words from fetch
  input wire logic [15:0] instr_word,
  input wire logic instr_valid,
  output logic instr_take,
  // data memory port
  output dmx_pkg::dmx_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  // core state
  output logic [7:0] work_reg,
  output logic [7:0] bank_select_register,
  output logic flags_wr,
  output dmx_pkg::dmx_phase_t q_phase
);
  import dmx_pkg::*;

  dmx_phase_t phase_r, phase_nxt; // current quarter of the cycle
  dmx_op_t op_r, op_nxt; // operation of this cycle
  logic second_r, second_nxt; // awaiting move destination word
  logic [11:0] src_r, src_nxt; // move source address
  logic [11:0] dst_r, dst_nxt; // move or store destination address
  logic [7:0] lit_r, lit_nxt; // literal of a load
  logic [7:0] data_r, data_nxt; // byte carried by a move
  logic [7:0] w_r, w_nxt; // working register
  logic [7:0] bsr_r, bsr_nxt; // bank select register
  dmx_mem_req_t mem_r, mem_nxt; // registered memory request
  logic [11:0] stw_addr; // formed store address

  // store address: access bank or banked by bank select
  always_comb begin
    if (!instr_word[DMX_ABIT_POS]) begin
      stw_addr = {(instr_word[7:0] < DMX_ACC_SPLIT) ? DMX_ACC_LO_BANK : DMX_ACC_HI_BANK, instr_word[7:0]};
    end else begin
      stw_addr = {bsr_r[3:0], instr_word[7:0]};
    end
  end

  // word is consumed in decode phase
  assign instr_take = (phase_r == DMX_Q1) && instr_valid;

  // next-state logic for phases, decode, data path and registers
  always_comb begin
    phase_nxt = phase_r;
    op_nxt = op_r;
    second_nxt = second_r;
    src_nxt = src_r;
    dst_nxt = dst_r;
    lit_nxt = lit_r;
    data_nxt = data_r;
    w_nxt = w_r;
    bsr_nxt = bsr_r;
    mem_nxt = mem_r;
    mem_nxt.rd = 1'b0;
    mem_nxt.wr = 1'b0;
    unique case (phase_r)
      DMX_Q1: begin
        phase_nxt = DMX_Q2;
        op_nxt = DMX_OP_NONE;
        if (second_r) begin
          // missing second word stalls a whole cycle
          if (!instr_valid) begin
            op_nxt = DMX_OP_STALL;
          end else begin
            second_nxt = 1'b0;
            if (instr_word[15:12] == DMX_OPC_MOVE2) begin
              op_nxt = DMX_OP_MV2;
              dst_nxt = instr_word[11:0];
            end
          end
        end else if (instr_valid) begin
          if (instr_word[15:12] == DMX_OPC_MOVE1) begin
            op_nxt = DMX_OP_MV1;
            second_nxt = 1'b1;
            src_nxt = instr_word[11:0];
            mem_nxt.rd = (instr_word[11:0] != DMX_W_ADDR);
            mem_nxt.addr = instr_word[11:0];
          end else if (instr_word[15:8] == DMX_OPC_LDB) begin
            op_nxt = DMX_OP_LDB;
            lit_nxt = instr_word[7:0];
          end else if (instr_word[15:8] == DMX_OPC_LDW) begin
            op_nxt = DMX_OP_LDW;
            lit_nxt = instr_word[7:0];
          end else if (instr_word[15:9] == DMX_OPC_STW) begin
            op_nxt = DMX_OP_STW;
            dst_nxt = stw_addr;
            mem_nxt.rd = (stw_addr != DMX_W_ADDR);
            mem_nxt.addr = stw_addr;
          end
        end
      end
      DMX_Q2: begin
        phase_nxt = DMX_Q3;
        if (op_r == DMX_OP_MV1) begin
          data_nxt = (src_r == DMX_W_ADDR) ? w_r : mem_rdata;
        end
      end
      DMX_Q3: begin
        phase_nxt = DMX_Q4;
        if (op_r == DMX_OP_MV2) begin
          mem_nxt.wr = (dst_r != DMX_W_ADDR);
          mem_nxt.addr = dst_r;
          mem_nxt.wdata = data_r;
        end else if (op_r == DMX_OP_STW) begin
          mem_nxt.wr = (dst_r != DMX_W_ADDR);
          mem_nxt.addr = dst_r;
          mem_nxt.wdata = w_r;
        end
      end
      DMX_Q4: begin
        phase_nxt = DMX_Q1;
        // register results at end of Q4
        unique case (op_r)
          DMX_OP_LDB: bsr_nxt = lit_r;
          DMX_OP_LDW: w_nxt = lit_r;
          DMX_OP_MV2: begin
            if (dst_r == DMX_W_ADDR) begin
              w_nxt = data_r;
            end
          end
          default: begin
          end
        endcase
      end
    endcase
  end

  // state registers
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      phase_r <= DMX_Q1;
      op_r <= DMX_OP_NONE;
      second_r <= 1'b0;
      src_r <= '0;
      dst_r <= '0;
      lit_r <= '0;
      data_r <= '0;
      w_r <= DMX_W_RST;
      bsr_r <= DMX_BSR_RST;
      mem_r <= '0;
    end else begin
      phase_r <= phase_nxt;
      op_r <= op_nxt;
      second_r <= second_nxt;
      src_r <= src_nxt;
      dst_r <= dst_nxt;
      lit_r <= lit_nxt;
      data_r <= data_nxt;
      w_r <= w_nxt;
      bsr_r <= bsr_nxt;
      mem_r <= mem_nxt;
    end
  end

  // outputs
  assign mem_req = mem_r;
  assign work_reg = w_r;
  assign bank_select_register = bsr_r;
  assign q_phase = phase_r;
  assign flags_wr = 1'b0;

  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  phase_seq_a: assert property (phase_r == DMX_Q1
                                |=> phase_r == DMX_Q2 ##1 phase_r == DMX_Q3 ##1 phase_r == DMX_Q4)
    else $error("phase order broken");
  move_read_a: assert property (phase_r == DMX_Q2 && op_r == DMX_OP_MV1 && src_r != DMX_W_ADDR
                                |-> mem_r.rd && !mem_r.wr && mem_r.addr == src_r)
    else $error("move source not read in Q2");
  move_nowr_a: assert property (op_r == DMX_OP_MV1 |-> !mem_r.wr)
    else $error("write during move first cycle");
  move_write_a: assert property (phase_r == DMX_Q4 && op_r == DMX_OP_MV2 && dst_r != DMX_W_ADDR
                                 |-> mem_r.wr && !mem_r.rd && mem_r.addr == dst_r && mem_r.wdata == data_r)
    else $error("move destination not written in Q4");
  move_order_a: assert property (phase_r == DMX_Q2 && op_r == DMX_OP_MV2
                                 |-> $past(op_r, 4) == DMX_OP_MV1 || $past(op_r, 4) == DMX_OP_STALL)
    else $error("second move word without first");
  move_to_w_a: assert property (phase_r == DMX_Q4 && op_r == DMX_OP_MV2 && dst_r == DMX_W_ADDR
                                |=> w_r == $past(data_r) && !$past(mem_r.wr))
    else $error("move into working register lost");
  bank_load_a: assert property (phase_r == DMX_Q4 && op_r == DMX_OP_LDB |=> bsr_r == $past(lit_r))
    else $error("bank literal not loaded");
  w_load_a: assert property (phase_r == DMX_Q4 && op_r == DMX_OP_LDW |=> w_r == $past(lit_r))
    else $error("working literal not loaded");
  store_wr_a: assert property (phase_r == DMX_Q4 && op_r == DMX_OP_STW && dst_r != DMX_W_ADDR
                               |-> mem_r.wr && mem_r.wdata == w_r && mem_r.addr == dst_r)
    else $error("store working not written");
  // a word taken while a move waits for its destination is never a store
  access_bank_a: assert property (instr_take && !second_r && instr_word[15:9] == DMX_OPC_STW
                                  && !instr_word[DMX_ABIT_POS] && instr_word[7:0] < DMX_ACC_SPLIT
                                  |=> dst_r[11:8] == DMX_ACC_LO_BANK)
    else $error("access bank not used");
  banked_a: assert property (instr_take && !second_r && instr_word[15:9] == DMX_OPC_STW
                             && instr_word[DMX_ABIT_POS]
                             |=> dst_r == {$past(bsr_r[3:0]), $past(instr_word[7:0])})
    else $error("bank select not used");
  flags_held_a: assert property (!flags_wr)
    else $error("status flags written");

  move_c: cover property (phase_r == DMX_Q4 && op_r == DMX_OP_MV2);
  stall_c: cover property (op_r == DMX_OP_STALL);
  store_c: cover property (phase_r == DMX_Q4 && op_r == DMX_OP_STW && mem_r.wr);
  load_c: cover property (op_r == DMX_OP_LDB ##4 op_r == DMX_OP_LDW);
endmodule

// File: design/dmx_pkg.sv
// constants, types and encodings for the data-move instruction executor
//
// Behaviour
// - file-to-file move reaches any 12-bit data address
// - first word 1100 source, second 1111 destination
// - file-to-file move handles working register endpoints
// - file-to-file move: two words, two cycles, stall three
// - move reads source Q2, writes destination Q4
// - bank literal load writes bank select register
// - working literal load writes working register
// - store working: read Q2, write Q4
// - store address picks byte within 256-byte bank
// - access bit zero selects access bank
// - access bit one uses bank select register
package dmx_pkg;
  // data space and word layout
  localparam int DMX_ADDR_W = 12;
  localparam int DMX_WORD_W = 16;
  localparam int DMX_DATA_W = 8;
  // opcode fields
  localparam logic [3:0] DMX_OPC_MOVE1 = 4'hc; // file-to-file first word
  localparam logic [3:0] DMX_OPC_MOVE2 = 4'hf; // file-to-file second word
  localparam logic [7:0] DMX_OPC_LDB = 8'h01; // bank literal load
  localparam logic [7:0] DMX_OPC_LDW = 8'h0e; // working literal load
  localparam logic [6:0] DMX_OPC_STW = 7'h37; // store working, access bit below
  localparam int DMX_ABIT_POS = 8; // position of the bank-access bit
  // address map of core registers and access bank
  localparam logic [11:0] DMX_W_ADDR = 12'hfe8; // working register in data space
  localparam logic [7:0] DMX_ACC_SPLIT = 8'h80; // low half of access bank below
  localparam logic [3:0] DMX_ACC_LO_BANK = 4'h0; // bank of low access half
  localparam logic [3:0] DMX_ACC_HI_BANK = 4'hf; // bank of high access half
  // reset values
  localparam logic [7:0] DMX_W_RST = 8'h00;
  localparam logic [7:0] DMX_BSR_RST = 8'h00;
  // instruction cycle phases
  typedef enum logic [1:0] {DMX_Q1, DMX_Q2, DMX_Q3, DMX_Q4} dmx_phase_t;
  // operation held for the current instruction cycle
  typedef enum logic [2:0] {DMX_OP_NONE, DMX_OP_MV1, DMX_OP_MV2, DMX_OP_STALL,
                            DMX_OP_LDB, DMX_OP_LDW, DMX_OP_STW} dmx_op_t;
  // data memory request
  typedef struct packed {
    logic rd;
    logic wr;
    logic [11:0] addr;
    logic [7:0] wdata;
  } dmx_mem_req_t;
endpackage

// File: sim/dmx_far_model.sv
// fetch stage and data memory model facing the executor
`timescale 1ns/1ps
module dmx_far_model (
  // clock
  input wire logic sys_clk,
  // fetch side
  output logic [15:0] instr_word,
  output logic instr_valid,
  input wire logic instr_take,
  input wire dmx_pkg::dmx_phase_t q_phase,
  // data side
  input wire dmx_pkg::dmx_mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  input wire logic flags_wr
);
  import dmx_pkg::*;
  logic [16:0] prg [64]; // words, bit 16 marks a gap
  logic [7:0] mem [4096]; // data space
  int hd = 0; // head word
  int tl = 0; // end of program
  int cyc = 0; // edge count
  int rd_cnt = 0; // reads seen
  int wr_cnt = 0; // writes seen
  int fl_cnt = 0; // flag writes seen
  int tk[$]; // edges of takes
  int wq[$]; // edges of writes
  // head word, a changing pattern when idle
  assign instr_valid = (hd < tl) && !prg[hd][16];
  assign instr_word = instr_valid ? prg[hd][15:0] : cyc[15:0];
  // read data only while a read is asked
  assign mem_rdata = mem_req.rd ? mem[mem_req.addr] : ~cyc[7:0];
  // consume words, log and store requests
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (hd < tl && q_phase == DMX_Q1 && (instr_take || prg[hd][16])) begin
      hd <= hd + 1;
    end
    if (instr_take && instr_valid) begin
      tk.push_back(cyc);
    end
    if (mem_req.rd) begin
      rd_cnt++;
    end
    if (flags_wr) begin
      fl_cnt++;
    end
    if (mem_req.wr) begin
      wr_cnt++;
      wq.push_back(cyc);
      mem[mem_req.addr] <= mem_req.wdata;
    end
  end
endmodule

// File: sim/data_move_instruction_exec_tb.sv
// self-checking bench of the data-move executor
`timescale 1ns/1ps
module data_move_instruction_exec_tb;
  import dmx_pkg::*;
  logic sys_clk = 1'b0; // core clock
  logic nrst = 1'b0; // reset, active low
  logic [15:0] instr_word; // fetch word
  logic instr_valid; // fetch valid
  logic instr_take; // word consumed
  dmx_mem_req_t mem_req; // memory request
  logic [7:0] mem_rdata; // memory data
  logic [7:0] work_reg; // working register
  logic [7:0] bank_select_register; // bank register
  logic flags_wr; // flag write enable
  dmx_phase_t q_phase; // phase
  int num_errors = 0; // mismatches
  int checks_done = 0; // comparisons
  int pend = 0; // words queued
  dmx_exec i_dut (.sys_clk(sys_clk), .nrst(nrst), .instr_word(instr_word),
    .instr_valid(instr_valid), .instr_take(instr_take), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .work_reg(work_reg),
    .bank_select_register(bank_select_register), .flags_wr(flags_wr), .q_phase(q_phase));
  dmx_far_model i_far (.sys_clk(sys_clk), .instr_word(instr_word), .instr_valid(instr_valid),
    .instr_take(instr_take), .q_phase(q_phase), .mem_req(mem_req), .mem_rdata(mem_rdata),
    .flags_wr(flags_wr));
  // 50 ns clock
  initial begin
    forever #25 sys_clk = ~sys_clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // verdict
  task automatic report_and_stop();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // programs never hit stack or interrupt registers
  task automatic put(input logic [16:0] w);
    i_far.prg[i_far.tl + pend] = w;
    pend++;
  endtask
  // run queued words, then check read and write counts
  task automatic go(input int nrd, input int nwr);
    int r0;
    int w0;
    int n;
    @(posedge sys_clk);
    r0 = i_far.rd_cnt;
    w0 = i_far.wr_cnt;
    i_far.tk.delete();
    i_far.wq.delete();
    i_far.tl <= i_far.tl + pend;
    pend = 0;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (i_far.hd != i_far.tl && n < 200);
    // a program that never drains counts as a mismatch
    if (n >= 200) begin
      num_errors++;
      $display("ERROR %0t program not consumed", $time);
    end
    repeat (8) @(posedge sys_clk);
    chk(16'(i_far.rd_cnt - r0), 16'(nrd));
    chk(16'(i_far.wr_cnt - w0), 16'(nwr));
  endtask
  // store target from access bit, file byte and bank
  function automatic logic [11:0] stw_at(input logic a, input logic [7:0] f, input logic [7:0] b);
    if (a) begin
      return {b[3:0], f};
    end
    return {(f < DMX_ACC_SPLIT) ? DMX_ACC_LO_BANK : DMX_ACC_HI_BANK, f};
  endfunction
  task automatic t_loads();
    put(17'h001f2);
    put(17'h00ea5);
    go(0, 0);
    chk({8'h00, bank_select_register}, 16'h00f2);
    chk({8'h00, work_reg}, 16'h00a5);
  endtask
  // corner move with a fetch stall
  task automatic t_move_stall();
    i_far.mem[0] = 8'h3c;
    put(17'h0c000);
    put(17'h10000);
    put(17'h0ffff);
    go(1, 1);
    chk(16'(i_far.tk[1] - i_far.tk[0]), 16'd8);
    chk(16'(i_far.wq[0] - i_far.tk[1]), 16'd3);
    chk({8'h00, i_far.mem[12'hfff]}, 16'h003c);
  endtask
  // back-to-back moves through the working register
  task automatic t_move_w();
    i_far.mem[12'h030] = 8'h69;
    put({5'h0c, DMX_W_ADDR});
    put(17'h0f020);
    put(17'h0c030);
    put({5'h0f, DMX_W_ADDR});
    go(1, 1);
    chk(16'(i_far.tk[1] - i_far.tk[0]), 16'd4);
    chk({8'h00, i_far.mem[12'h020]}, 16'h00a5);
    chk({8'h00, work_reg}, 16'h0069);
  endtask
  // stores in banked and access modes
  task automatic t_store();
    put(17'h00102);
    put(17'h06fff);
    put(17'h06e10);
    put(17'h06e90);
    go(3, 3);
    chk(16'(i_far.wq[2] - i_far.tk[3]), 16'd3);
    chk({8'h00, i_far.mem[stw_at(1'b1, 8'hff, 8'h02)]}, 16'h0069);
    chk({8'h00, i_far.mem[stw_at(1'b0, 8'h10, 8'h02)]}, 16'h0069);
    chk({8'h00, i_far.mem[stw_at(1'b0, 8'h90, 8'h02)]}, 16'h0069);
  endtask
  // second word without 1111 is consumed and the move dropped
  task automatic t_move_abort();
    put(17'h0c030);
    put(17'h06e20);
    go(1, 0);
    chk(16'(i_far.tk.size()), 16'd2);
    chk({8'h00, i_far.mem[12'h020]}, 16'h00a5);
    chk({8'h00, work_reg}, 16'h0069);
  endtask
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk);
    nrst <= 1'b1;
    t_loads();
    t_move_stall();
    t_move_w();
    t_store();
    t_move_abort();
    chk(16'(i_far.fl_cnt), 16'd0);
    report_and_stop();
  end
  // watchdog
  initial begin
    repeat (3000) @(posedge sys_clk);
    num_errors++;
    report_and_stop();
  end
endmodule
